// File: verilog/mrws_pkg.sv
// constants and types shared by the multi-rail supervisor
package mrws_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int NUM_RAILS = 6;
    localparam int CNT_W = 28;
    localparam int OVR_W = 16;
    localparam int ADDR_W = 8;
    localparam int EVT_W = 4;

    function automatic int ms_to_cyc(input int ms);
        return ms * (CLK_HZ / 1000);
    endfunction : ms_to_cyc

    function automatic int us_to_cyc(input int us);
        return us * (CLK_HZ / 1_000_000);
    endfunction : us_to_cyc

    // times in their own units, cycle counts derived
    localparam int STRETCH_MS = 140;
    localparam int STRETCH_MAX_MS = 1120;
    localparam int WD_PERIOD_MS = 1600;
    localparam int MR_DEBOUNCE_US = 1000;
    localparam int OVR_DELAY_US = 10;
    localparam int STRETCH_CYC = ms_to_cyc(STRETCH_MS);
    localparam int STRETCH_MAX_CYC = ms_to_cyc(STRETCH_MAX_MS);
    localparam int WD_CYC = ms_to_cyc(WD_PERIOD_MS);
    localparam int MR_DEB_CYC = us_to_cyc(MR_DEBOUNCE_US);
    localparam int OVR_CYC = us_to_cyc(OVR_DELAY_US);

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STRETCH = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_STATE = 8'h10;

    // fields and reset values
    localparam int CTRL_WDO_SEP_BIT = 0;
    localparam logic CTRL_WDO_SEP_RST = 1'b0;
    localparam logic [EVT_W-1:0] MASK_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic rst_release;
        logic wd_expire;
        logic manual;
        logic rail_fault;
    } mrws_evt_t;

    typedef struct packed {
        logic wdo_latch;
        logic rst_int;
        logic wd_armed;
        logic margin;
        logic tsel;
        logic [NUM_RAILS-1:0] rail_low;
    } mrws_state_t;

endpackage : mrws_pkg

// File: verilog/mrws_pin_filter.sv
// three-stage pin synchroniser with stable-time filter
`timescale 1ns/1ps
`default_nettype none
module mrws_pin_filter #(
    parameter logic INIT = 1'b1,
    parameter int HOLD = 1
)(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic pin, // raw pin level
    output logic level // filtered level
);

    logic ff1_r;
    logic ff2_r;
    logic ff3_r;
    logic [31:0] cnt_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            ff1_r <= INIT;
            ff2_r <= INIT;
            ff3_r <= INIT;
        end else begin
            ff1_r <= pin;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // new level only after it has stood agreed for hold cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            level <= INIT;
        end else if (ff2_r == ff3_r && ff3_r != level) begin
            if (cnt_r >= 32'(HOLD - 1)) begin
                level <= ff3_r;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end else begin
            cnt_r <= '0;
        end
    end

    debounce_hold_a: assert property (@(posedge clk) disable iff (rst)
        $changed(level) |-> $past(cnt_r) >= 32'(HOLD - 1))
        else $error("filtered level changed before hold time");

endmodule : mrws_pin_filter
`default_nettype wire

// File: verilog/mrws_top.sv
// multi-rail reset and watchdog supervisor with axi4-lite registers
//
// How it works
// - each rail flag goes low while its rail is below threshold, releases after.
// - combined reset goes low on any low rail or held manual reset.
// - after all good and manual released, reset stays low the stretch period.
// - timeout-select high picks the fixed internal 140 ms stretch.
// - timeout-select low uses a software stretch count up to 1.12 s.
// - manual reset reads as released when left unconnected.
// - bouncing manual reset contact is filtered into one clean assertion.
// - separate watchdog output follows low rails, releases with no delay.
// - watchdog output falls on expiry, releases on kick edge or manual reset.
// - watchdog counts only once the reset stretch has elapsed.
// - no kick within 1.6 s asserts reset or the watchdog output.
// - floating kick input disables the watchdog.
// - margin override low forces all outputs high and frozen unless under lockout.
// - watchdog runs during margin; outputs assert a fixed delay after release.
// - margin override reads inactive high when unconnected.
// - tolerance select low picks 5 percent band, high picks 10 percent.
// - under lockout all outputs hold their asserted states.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mrws_top
    import mrws_pkg::*;
#(
    parameter int STRETCH_CYC_P = STRETCH_CYC,
    parameter int STRETCH_MAX_P = STRETCH_MAX_CYC,
    parameter int WD_CYC_P = WD_CYC,
    parameter int MR_DEB_CYC_P = MR_DEB_CYC
)(
    input wire logic MCLK, // system clock
    input wire logic RESET, // synchronous reset, high
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write address
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // write byte enables
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    output logic [1:0] S_AXI_BRESP, // write response
    output logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_BREADY, // write response ready
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read address
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY, // read data ready
    input wire logic [NUM_RAILS-1:0] RAIL_LOW, // comparators, high = below
    input wire logic SUPPLY_OK, // supply above lockout level
    input wire logic MANUAL_RESET_N, // manual reset pin
    input wire logic MARGIN_N, // margin override pin
    input wire logic WATCHDOG_KICK_IN, // watchdog kick pin
    input wire logic KICK_FLOAT, // kick pin sensed open
    input wire logic TOLERANCE_SELECT, // threshold band pin
    input wire logic TIMEOUT_SELECT_PIN, // high = internal stretch
    output logic SYS_RESET_N, // combined reset
    output logic WATCHDOG_FAULT_N, // separate watchdog output
    output logic [NUM_RAILS-1:0] RAIL_FLAG_N, // per-rail flags
    output logic THRESH_BAND_HIGH, // 10 percent band to comparators
    output logic IRQ // interrupt, high level
);

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction : strb_merge

    function automatic logic reg_known(input logic [ADDR_W-1:0] a);
        return a == REG_CTRL || a == REG_STRETCH || a == REG_STATUS ||
               a == REG_MASK || a == REG_STATE;
    endfunction : reg_known

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic mr_s;
    logic margin_s;
    logic kick_s;
    logic float_s;
    logic tol_s;
    logic tsel_s;
    logic supply_s;

    // unconnected manual reset pulls high: starts released
    mrws_pin_filter #(.INIT(1'b1), .HOLD(MR_DEB_CYC_P)) u_mr (
        .clk(MCLK), .rst(RESET), .pin(MANUAL_RESET_N), .level(mr_s));
    // unconnected margin pulls high: starts inactive
    mrws_pin_filter #(.INIT(1'b1), .HOLD(1)) u_margin (
        .clk(MCLK), .rst(RESET), .pin(MARGIN_N), .level(margin_s));
    mrws_pin_filter #(.INIT(1'b0), .HOLD(1)) u_kick (
        .clk(MCLK), .rst(RESET), .pin(WATCHDOG_KICK_IN), .level(kick_s));
    mrws_pin_filter #(.INIT(1'b1), .HOLD(1)) u_float (
        .clk(MCLK), .rst(RESET), .pin(KICK_FLOAT), .level(float_s));
    mrws_pin_filter #(.INIT(1'b0), .HOLD(1)) u_tol (
        .clk(MCLK), .rst(RESET), .pin(TOLERANCE_SELECT), .level(tol_s));
    mrws_pin_filter #(.INIT(1'b1), .HOLD(1)) u_tsel (
        .clk(MCLK), .rst(RESET), .pin(TIMEOUT_SELECT_PIN), .level(tsel_s));
    mrws_pin_filter #(.INIT(1'b0), .HOLD(1)) u_supply (
        .clk(MCLK), .rst(RESET), .pin(SUPPLY_OK), .level(supply_s));

    ////////////////////////////////////////////////////////////////////////////////
    // reset stretch

    logic wdo_sep_r;
    logic [CNT_W-1:0] stretch_reg_r;
    logic [CNT_W-1:0] stretch_cnt_r;
    logic [CNT_W-1:0] stretch_len;
    logic rst_int_r;
    logic rst_cond;
    logic any_low;
    logic wd_expire;

    assign any_low = |RAIL_LOW;
    assign stretch_len = tsel_s ? CNT_W'(STRETCH_CYC_P) : stretch_reg_r;
    assign rst_cond = any_low || !mr_s || !supply_s || (wd_expire && !wdo_sep_r);

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            stretch_cnt_r <= '0;
            rst_int_r <= 1'b1;
        end else if (rst_cond) begin
            stretch_cnt_r <= '0;
            rst_int_r <= 1'b1;
        end else if (rst_int_r) begin
            if (stretch_cnt_r >= stretch_len - 1'b1) begin
                stretch_cnt_r <= '0;
                rst_int_r <= 1'b0;
            end else begin
                stretch_cnt_r <= stretch_cnt_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog

    logic kick_d_r;
    logic kick_edge;
    logic [CNT_W-1:0] wd_cnt_r;
    logic wdo_latch_r;
    logic wd_run;

    assign kick_edge = kick_s ^ kick_d_r;
    assign wd_run = !rst_int_r && !float_s && !any_low;
    assign wd_expire = wd_run && !kick_edge && wd_cnt_r == CNT_W'(WD_CYC_P - 1);

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            kick_d_r <= 1'b0;
        end else begin
            kick_d_r <= kick_s;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET || !wd_run || kick_edge || wd_expire) begin
            wd_cnt_r <= '0;
        end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            wdo_latch_r <= 1'b0;
        end else if (wd_expire && wdo_sep_r) begin
            wdo_latch_r <= 1'b1;
        end else if (kick_edge || !mr_s) begin
            wdo_latch_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // margin override and output stage

    logic [OVR_W-1:0] ovr_cnt_r;
    logic live;

    assign live = supply_s && margin_s && ovr_cnt_r == '0;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ovr_cnt_r <= '0;
        end else if (!margin_s) begin
            ovr_cnt_r <= OVR_W'(OVR_CYC);
        end else if (ovr_cnt_r != '0) begin
            ovr_cnt_r <= ovr_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET || !supply_s) begin
            SYS_RESET_N <= 1'b0;
            WATCHDOG_FAULT_N <= 1'b0;
            RAIL_FLAG_N <= '0;
        end else if (!live) begin
            SYS_RESET_N <= 1'b1;
            WATCHDOG_FAULT_N <= 1'b1;
            RAIL_FLAG_N <= '1;
        end else begin
            // low from the cause's own edge, not one stretch-state later
            SYS_RESET_N <= !(rst_int_r || rst_cond);
            WATCHDOG_FAULT_N <= !(wdo_sep_r && (any_low || wdo_latch_r));
            RAIL_FLAG_N <= ~RAIL_LOW;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            THRESH_BAND_HIGH <= 1'b0;
        end else begin
            THRESH_BAND_HIGH <= tol_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // events and interrupt

    logic any_low_d_r;
    logic mr_d_r;
    logic rst_int_d_r;
    mrws_evt_t evt;
    logic [EVT_W-1:0] status_r;
    logic [EVT_W-1:0] mask_r;
    logic [EVT_W-1:0] status_clr;

    assign evt.rail_fault = any_low && !any_low_d_r;
    assign evt.manual = !mr_s && mr_d_r;
    assign evt.wd_expire = wd_expire;
    assign evt.rst_release = rst_int_d_r && !rst_int_r;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            any_low_d_r <= 1'b0;
            mr_d_r <= 1'b1;
            rst_int_d_r <= 1'b1;
        end else begin
            any_low_d_r <= any_low;
            mr_d_r <= mr_s;
            rst_int_d_r <= rst_int_r;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            status_r <= '0;
            IRQ <= 1'b0;
        end else begin
            status_r <= (status_r & ~status_clr) | evt;
            IRQ <= |(status_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    logic aw_take;
    logic ar_take;
    logic [31:0] wmerged;
    logic [31:0] rd_data;
    mrws_state_t state;

    assign aw_take = S_AXI_AWREADY && S_AXI_AWVALID;
    assign ar_take = S_AXI_ARREADY && S_AXI_ARVALID;
    assign wmerged = strb_merge(32'(stretch_reg_r), S_AXI_WDATA, S_AXI_WSTRB);
    assign status_clr = (aw_take && S_AXI_AWADDR == REG_STATUS && S_AXI_WSTRB[0]) ?
                        S_AXI_WDATA[EVT_W-1:0] : '0;
    assign state = '{wdo_latch: wdo_latch_r, rst_int: rst_int_r, wd_armed: !rst_int_r,
                     margin: margin_s, tsel: tsel_s, rail_low: RAIL_LOW};

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !S_AXI_AWREADY && S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
            S_AXI_WREADY <= !S_AXI_AWREADY && S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
            if (aw_take) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= reg_known(S_AXI_AWADDR) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            wdo_sep_r <= CTRL_WDO_SEP_RST;
            stretch_reg_r <= CNT_W'(STRETCH_CYC_P);
            mask_r <= MASK_RST;
        end else if (aw_take) begin
            if (S_AXI_AWADDR == REG_CTRL && S_AXI_WSTRB[0]) begin
                wdo_sep_r <= S_AXI_WDATA[CTRL_WDO_SEP_BIT];
            end
            if (S_AXI_AWADDR == REG_STRETCH) begin
                // clamp into the supported stretch range
                if (wmerged == 32'h0) begin
                    stretch_reg_r <= CNT_W'(1);
                end else if (wmerged > 32'(STRETCH_MAX_P)) begin
                    stretch_reg_r <= CNT_W'(STRETCH_MAX_P);
                end else begin
                    stretch_reg_r <= wmerged[CNT_W-1:0];
                end
            end
            if (S_AXI_AWADDR == REG_MASK && S_AXI_WSTRB[0]) begin
                mask_r <= S_AXI_WDATA[EVT_W-1:0];
            end
        end
    end

    always_comb begin
        case (S_AXI_ARADDR)
            REG_CTRL: rd_data = 32'(wdo_sep_r);
            REG_STRETCH: rd_data = 32'(stretch_reg_r);
            REG_STATUS: rd_data = 32'(status_r);
            REG_MASK: rd_data = 32'(mask_r);
            REG_STATE: rd_data = 32'(state);
            default: rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && S_AXI_ARVALID && !S_AXI_RVALID;
            if (ar_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_data;
                S_AXI_RRESP <= reg_known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    flag_follow_a: assert property (live && RAIL_LOW[0] |=> !RAIL_FLAG_N[0])
        else $error("rail flag not low for low rail");
    reset_assert_a: assert property (live && (any_low || !mr_s) |=> !SYS_RESET_N)
        else $error("reset not asserted on fault");
    stretch_done_a: assert property ($fell(rst_int_r) |->
        $past(stretch_cnt_r) >= $past(stretch_len) - 1 && $past(!rst_cond))
        else $error("reset released before stretch elapsed");
    internal_len_a: assert property (tsel_s && rst_int_r && !rst_cond |->
        stretch_cnt_r < CNT_W'(STRETCH_CYC_P) || stretch_len != CNT_W'(STRETCH_CYC_P))
        else $error("internal stretch overran");
    ext_range_a: assert property (stretch_reg_r >= CNT_W'(1) &&
        stretch_reg_r <= CNT_W'(STRETCH_MAX_P))
        else $error("stretch register out of range");
    wdo_rail_a: assert property (live && wdo_sep_r && any_low |=> !WATCHDOG_FAULT_N)
        else $error("watchdog output not low on low rail");
    wdo_expire_a: assert property (wd_expire && wdo_sep_r |=> wdo_latch_r)
        else $error("watchdog expiry not latched");
    wd_hold_a: assert property (rst_int_r |=> wd_cnt_r == '0)
        else $error("watchdog counting during reset");
    wd_reset_a: assert property (wd_expire && !wdo_sep_r |=> rst_int_r[*2])
        else $error("watchdog expiry did not assert reset");
    wd_float_a: assert property (float_s |=> wd_cnt_r == '0 && !wd_expire)
        else $error("watchdog ran with kick floating");
    margin_force_a: assert property (supply_s && !margin_s |=>
        SYS_RESET_N && WATCHDOG_FAULT_N && &RAIL_FLAG_N)
        else $error("outputs not forced high in margin");
    ovr_delay_a: assert property ($rose(margin_s) |-> ovr_cnt_r == OVR_W'(OVR_CYC))
        else $error("release delay not loaded");
    uvlo_hold_a: assert property (!supply_s |=> !SYS_RESET_N && !WATCHDOG_FAULT_N)
        else $error("outputs not held under lockout");

endmodule : mrws_top
`default_nettype wire

// File: sim/mrws_cpu_model.sv
// processor model that services the watchdog kick pin
`timescale 1ns/1ps
`default_nettype none
module mrws_cpu_model #(
    parameter int GAP = 20
)(
    input wire logic clk, // system clock
    input wire logic rst_n_in, // combined reset from supervisor
    input wire logic en, // servicing switched on
    output logic kick // kick pin
);
    int cnt = 0;
    initial kick = 1'b0;
    // services only while out of reset; every toggle is one service
    always @(posedge clk) begin
        cnt <= (en && rst_n_in === 1'b1) ? cnt + 1 : 0;
        if (cnt == GAP - 1) begin
            kick <= ~kick;
            cnt <= 0;
        end
    end
endmodule : mrws_cpu_model
`default_nettype wire

// File: sim/mrws_top_tb.sv
// self-checking bench for the multi-rail supervisor
`timescale 1ns/1ps
`default_nettype none
module mrws_top_tb;
    import mrws_pkg::*;
    localparam int ST = 20;
    localparam int WD = 50;
    typedef struct packed {logic [1:0] resp; logic [31:0] data;} mrws_note_t;
    mrws_note_t notes[$];
    int n_errors = 0, compares = 0, cycles = 0, n, lows;
    logic [31:0] seed = 32'h19f7;
    logic [5:0] m;
    logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, arvalid = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, sys_rst_n, wdo_n, band, irq, kick;
    logic [5:0] rail_low = 0, flag_n;
    logic supply_ok = 1, mr_n = 1, margin_n = 1, kick_float = 1, tolerance_select = 0, tsel = 1;
    logic kick_en = 0, bready = 0, rready = 0;
    always #5 mclk = ~mclk;
    mrws_top #(.STRETCH_CYC_P(ST), .STRETCH_MAX_P(200), .WD_CYC_P(WD), .MR_DEB_CYC_P(4)) dut (
        .MCLK(mclk), .RESET(reset), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .RAIL_LOW(rail_low), .SUPPLY_OK(supply_ok), .MANUAL_RESET_N(mr_n),
        .MARGIN_N(margin_n), .WATCHDOG_KICK_IN(kick), .KICK_FLOAT(kick_float),
        .TOLERANCE_SELECT(tolerance_select), .TIMEOUT_SELECT_PIN(tsel), .SYS_RESET_N(sys_rst_n),
        .WATCHDOG_FAULT_N(wdo_n), .RAIL_FLAG_N(flag_n), .THRESH_BAND_HIGH(band), .IRQ(irq));
    mrws_cpu_model #(.GAP(20)) cpu (.clk(mclk), .rst_n_in(sys_rst_n), .en(kick_en), .kick(kick));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wrap_up;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc
    // cycles until reset (w=0) or watchdog output (w=1) shows level v
    task automatic until_lvl(input logic w, input logic v, output int k);
        k = 0;
        while ((w ? wdo_n : sys_rst_n) !== v && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        chk("level", 32'(v), 32'(w ? wdo_n : sys_rst_n));
    endtask : until_lvl
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        notes.push_back('{r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (bvalid !== 1'b1) @(posedge mclk);
        bready <= 1'b0;
        @(posedge mclk);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        notes.push_back('{r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge mclk);
        rready <= 1'b0;
        @(posedge mclk);
    endtask : axr
    // takes the oldest note whenever a response appears
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
        if (bvalid === 1'b1 || rvalid === 1'b1) begin
            if (notes.size() == 0) chk("note queue", 32'h1, 32'h0);
            else begin
                chk("resp", 32'(notes[0].resp), 32'(bvalid ? bresp : rresp));
                chk("rdata", notes[0].data, bvalid ? 32'h0 : rdata);
                void'(notes.pop_front());
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(3);
        reset <= 1'b0;
        cyc(60);
        axr(REG_CTRL, 32'h0, RESP_OKAY);
        axr(REG_STRETCH, 32'(ST), RESP_OKAY);
        axr(REG_MASK, 32'h0, RESP_OKAY);
        axw(8'h14, 32'h1, RESP_SLVERR);
        axr(8'h14, 32'h0, RESP_SLVERR);
        repeat (3) begin
            seed = lfsr(seed);
            m = 6'(1 << (seed % 6));
            rail_low <= m;
            cyc(2);
            chk("flag", {26'h0, ~m}, {26'h0, flag_n});
            chk("rst", 0, sys_rst_n);
            cyc(5);
            rail_low <= 6'h0;
            until_lvl(0, 1, n);
            chk("stretch", 1, 32'(n >= ST && n <= ST + 8));
            chk("flag", 32'h3f, {26'h0, flag_n});
        end
        chk("irq", 0, irq);
        axr(REG_STATUS, 32'h9, RESP_OKAY);
        axw(REG_MASK, 32'h1, RESP_OKAY);
        cyc(2);
        chk("irq", 1, irq);
        axw(REG_STATUS, 32'h1, RESP_OKAY);
        cyc(2);
        chk("irq", 0, irq);
        axr(REG_STATUS, 32'h8, RESP_OKAY);
        axw(REG_MASK, 32'h0, RESP_OKAY);
        mr_n <= 1'b0;
        cyc(1);
        mr_n <= 1'b1;
        cyc(15);
        chk("rst", 1, sys_rst_n);
        repeat (3) begin
            mr_n <= ~mr_n;
            cyc(1);
        end
        cyc(20);
        chk("rst", 0, sys_rst_n);
        mr_n <= 1'b1;
        until_lvl(0, 1, n);
        chk("mr stretch", 1, 32'(n >= ST && n <= ST + 15));
        tsel <= 1'b0;
        axw(REG_STRETCH, 32'd60, RESP_OKAY);
        rail_low <= 6'h20;
        cyc(3);
        rail_low <= 6'h0;
        until_lvl(0, 1, n);
        chk("ext stretch", 1, 32'(n >= 60 && n <= 68));
        axw(REG_STRETCH, 32'hffff, RESP_OKAY);
        axr(REG_STRETCH, 32'd200, RESP_OKAY);
        tsel <= 1'b1;
        tolerance_select <= 1'b1;
        cyc(6);
        chk("band", 1, band);
        tolerance_select <= 1'b0;
        cyc(6);
        chk("band", 0, band);
        kick_float <= 1'b0;
        kick_en <= 1'b1;
        lows = 0;
        repeat (300) begin
            @(posedge mclk);
            if (sys_rst_n !== 1'b1) lows++;
        end
        chk("serviced", 0, lows);
        kick_en <= 1'b0;
        until_lvl(0, 0, n);
        chk("wd expiry", 1, 32'(n >= WD - 22 && n <= WD + 10));
        kick_en <= 1'b1;
        until_lvl(0, 1, n);
        chk("wd stretch", 1, 32'(n >= ST));
        cyc(200);
        chk("rst", 1, sys_rst_n);
        axw(REG_CTRL, 32'h1, RESP_OKAY);
        kick_en <= 1'b0;
        until_lvl(1, 0, n);
        chk("wdo expiry", 1, 32'(n <= WD + 10));
        chk("rst", 1, sys_rst_n);
        kick_en <= 1'b1;
        until_lvl(1, 1, n);
        chk("wdo kick", 1, 32'(n <= 30));
        kick_en <= 1'b0;
        until_lvl(1, 0, n);
        mr_n <= 1'b0;
        cyc(12);
        chk("wdo mr", 1, wdo_n);
        kick_en <= 1'b1;
        mr_n <= 1'b1;
        until_lvl(0, 1, n);
        rail_low <= 6'h01;
        cyc(3);
        chk("wdo rail", 0, wdo_n);
        rail_low <= 6'h0;
        cyc(3);
        chk("wdo rail", 1, wdo_n);
        chk("rst", 0, sys_rst_n);
        until_lvl(0, 1, n);
        kick_en <= 1'b0;
        kick_float <= 1'b1;
        cyc(300);
        chk("wdo off", 1, wdo_n);
        axw(REG_CTRL, 32'h0, RESP_OKAY);
        margin_n <= 1'b0;
        cyc(6);
        rail_low <= 6'h3f;
        cyc(4);
        chk("margin", 32'h7f, {25'h0, flag_n, sys_rst_n});
        chk("margin", 1, wdo_n);
        margin_n <= 1'b1;
        cyc(500);
        chk("margin hold", 1, sys_rst_n);
        until_lvl(0, 0, n);
        chk("margin end", 1, 32'(n <= 600));
        rail_low <= 6'h0;
        until_lvl(0, 1, n);
        supply_ok <= 1'b0;
        cyc(6);
        chk("uvlo", 0, {25'h0, flag_n, sys_rst_n});
        supply_ok <= 1'b1;
        until_lvl(0, 1, n);
        chk("uvlo end", 32'h3f, {26'h0, flag_n});
        wrap_up();
    end
endmodule : mrws_top_tb
`default_nettype wire
